// [common/csbs_pkg.sv]
// How it works
// - interleaved mode: bit 0 picks the module, bit 16 picks the bank
// - straight mode: bit 16 picks the bank, bit 15 picks the module
// - remaining 15 address bits go to the chosen module's address register
// - each module holds 32,768 words of 30 bits plus two hidden parity bits
// - interleaved is normal: odd and even addresses go to different modules
// - a manual mode input selects straight addressing to bypass a module
// - decode serves one bank of two modules or two banks of two modules each
// - transfers: double words, full words, half words and selected bit fields
// - two different modules may run storage cycles at the same time
// - a module grants the request in the same cycle that it accepts the address
// - a module acknowledges once a read or write reference completes
// - a module cycle of 750 ns is rounded up to 8 clocks of 100 ns; no new reference to it before then
// - half-word parity is generated on writes and checked on reads
// - a parity mismatch on read raises a parity interrupt
// - after a parity error the word is restored unchanged
// - parity interrupts are reported separately for each bank
package csbs_pkg;
  localparam int CSBS_ADDR_W = 17;
  localparam int CSBS_IDX_W = 15;
  localparam int CSBS_DATA_W = 30;
  localparam int CSBS_HALF_W = 15;
  localparam int CSBS_DBL_W = 60;
  localparam int CSBS_PORTS = 2;
  localparam int CSBS_BANKS = 2;
  localparam int CSBS_MODS = 4;
  localparam int CSBS_MOD_WORDS = 32768;
  localparam int CSBS_BANK_BIT = 16;
  localparam int CSBS_STR_MOD_BIT = 15;
  localparam int CSBS_ILV_MOD_BIT = 0;
  localparam int CSBS_CYCLE_NS = 750;
  localparam int CSBS_CLK_NS = 100;
  localparam int CSBS_CYCLE_CYC = (CSBS_CYCLE_NS + CSBS_CLK_NS - 1) / CSBS_CLK_NS;
  localparam int CSBS_CNT_W = 4;
  localparam logic [CSBS_CNT_W-1:0] CSBS_READ_CNT = 4'h0;
  localparam logic [CSBS_CNT_W-1:0] CSBS_RESTORE_CNT = 4'h1;
  localparam logic [CSBS_CNT_W-1:0] CSBS_LAST_CNT = CSBS_CNT_W'(CSBS_CYCLE_CYC - 2);
  localparam logic [CSBS_DATA_W-1:0] CSBS_UPPER_MASK = 30'h3fff8000;
  localparam logic [CSBS_DATA_W-1:0] CSBS_LOWER_MASK = 30'h00007fff;
  localparam logic [CSBS_DATA_W-1:0] CSBS_FULL_MASK = 30'h3fffffff;

  typedef enum logic [2:0] {
    CSBS_FULL = 3'h0,
    CSBS_UPPER = 3'h1,
    CSBS_LOWER = 3'h2,
    CSBS_FIELD = 3'h3,
    CSBS_DOUBLE = 3'h4
  } csbs_kind_t;

  typedef enum logic {
    CSBS_M_IDLE = 1'b0,
    CSBS_M_BUSY = 1'b1
  } csbs_mst_t;

  typedef enum logic [1:0] {
    CSBS_P_IDLE = 2'b00,
    CSBS_P_ASK = 2'b01,
    CSBS_P_WAIT = 2'b10
  } csbs_pst_t;

  typedef struct packed {
    logic valid;
    logic write;
    csbs_kind_t kind;
    logic [CSBS_ADDR_W-1:0] addr;
    logic [CSBS_DATA_W-1:0] mask;
    logic [CSBS_DBL_W-1:0] wdata;
  } csbs_req_t;

  typedef struct packed {
    logic par_hi;
    logic par_lo;
    logic [CSBS_DATA_W-1:0] data;
  } csbs_word_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [CSBS_IDX_W-1:0] addr;
    logic [CSBS_DATA_W-1:0] mask;
    logic [CSBS_DATA_W-1:0] wdata;
  } csbs_mreq_t;

  typedef struct packed {
    logic ack;
    logic perr;
    logic [CSBS_DATA_W-1:0] rdata;
  } csbs_mrsp_t;

  typedef struct packed {
    csbs_mst_t mst;
    logic [CSBS_CNT_W-1:0] cnt;
    logic write;
    logic [CSBS_IDX_W-1:0] addr;
    logic [CSBS_DATA_W-1:0] mask;
    logic [CSBS_DATA_W-1:0] wdata;
    csbs_word_t rword;
    logic perr;
    logic perr_p;
    logic ack;
  } csbs_mod_t;

  typedef struct packed {
    csbs_pst_t pst;
    logic second;
    logic [1:0] mod;
    csbs_req_t req;
    logic ack;
    logic aerr;
    logic [CSBS_DBL_W-1:0] rdata;
  } csbs_port_t;

  typedef struct packed {
    logic [1:0] sw_s1;
    logic [1:0] sw_s2;
    logic [CSBS_BANKS-1:0] par_int;
    csbs_port_t [CSBS_PORTS-1:0] port;
  } csbs_top_t;

  localparam csbs_mod_t CSBS_MOD_RST = '0;
  localparam csbs_top_t CSBS_TOP_RST = '0;
endpackage

// [design/csbs_parity.sv]
`timescale 1ns/1ps
module csbs_parity #(
  parameter int W = 15
) (
  // one half-word and its stored parity bit
  input wire logic [W-1:0] data_in,
  input wire logic stored_in,
  // fresh parity and mismatch flag
  output logic gen_out,
  output logic err_out
);
  assign gen_out = ~^data_in;
  assign err_out = ~(^{data_in, stored_in});
endmodule

// [design/csbs_module.sv]
`timescale 1ns/1ps
module csbs_module
  import csbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // request from the select logic
  input csbs_mreq_t mreq_in,
  output logic gnt_out,
  // answer
  output csbs_mrsp_t rsp_out
);
  csbs_mod_t st;
  csbs_mod_t next_st;
  csbs_word_t mem [CSBS_MOD_WORDS];
  csbs_word_t rd_word;
  csbs_word_t wr_word;
  logic [CSBS_DATA_W-1:0] merged;
  logic gen_hi, gen_lo, err_hi, err_lo, wr_en;
  logic chk_rd;

  assign rd_word = mem[st.addr];
  assign merged = (st.rword.data & ~st.mask) | (st.wdata & st.mask);

  csbs_parity #(.W(CSBS_HALF_W)) u_chk_hi (.data_in(rd_word.data[29:15]), .stored_in(rd_word.par_hi),
    .gen_out(), .err_out(err_hi));
  csbs_parity #(.W(CSBS_HALF_W)) u_chk_lo (.data_in(rd_word.data[14:0]), .stored_in(rd_word.par_lo),
    .gen_out(), .err_out(err_lo));
  csbs_parity #(.W(CSBS_HALF_W)) u_gen_hi (.data_in(merged[29:15]), .stored_in(1'b0),
    .gen_out(gen_hi), .err_out());
  csbs_parity #(.W(CSBS_HALF_W)) u_gen_lo (.data_in(merged[14:0]), .stored_in(1'b0),
    .gen_out(gen_lo), .err_out());

  // a full-word write replaces both halves, so stale or unwritten parity must not drop it
  assign chk_rd = !st.write || st.mask != CSBS_FULL_MASK;
  assign gnt_out = mreq_in.sel && st.mst == CSBS_M_IDLE;
  assign wr_en = st.mst == CSBS_M_BUSY && st.cnt == CSBS_RESTORE_CNT;
  // reads are destructive in core, so every cycle restores; a bad word goes back as read
  assign wr_word = (st.write && !st.perr) ? csbs_word_t'{par_hi: gen_hi, par_lo: gen_lo, data: merged}
                                          : st.rword;
  assign rsp_out = '{ack: st.ack, perr: st.perr_p, rdata: st.rword.data};

  always_ff @(posedge sys_clk_in)
  begin
    if (wr_en)
    begin
      mem[st.addr] <= wr_word;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.perr_p = 1'b0;
    unique case (st.mst)
      CSBS_M_IDLE:
      begin
        if (gnt_out)
        begin
          next_st.mst = CSBS_M_BUSY;
          next_st.cnt = '0;
          next_st.write = mreq_in.write;
          next_st.addr = mreq_in.addr;
          next_st.mask = mreq_in.mask;
          next_st.wdata = mreq_in.wdata;
          next_st.perr = 1'b0;
        end
      end
      CSBS_M_BUSY:
      begin
        next_st.cnt = st.cnt + 4'h1;
        if (st.cnt == CSBS_READ_CNT)
        begin
          next_st.rword = rd_word;
          next_st.perr = (err_hi | err_lo) && chk_rd;
          next_st.perr_p = (err_hi | err_lo) && chk_rd;
        end
        if (st.cnt == CSBS_LAST_CNT)
        begin
          next_st.mst = CSBS_M_IDLE;
          next_st.ack = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st <= CSBS_MOD_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  localparam int ACK_DLY = CSBS_CYCLE_CYC;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_cycle_ack: assert property (gnt_out |-> ##ACK_DLY rsp_out.ack)
    else $error("module ack not at end of cycle");
  chk_no_overlap: assert property (gnt_out |=> (!gnt_out)[*7])
    else $error("module regranted inside its cycle");
  chk_restore_same: assert property (wr_en && st.perr |-> wr_word == st.rword)
    else $error("bad word not restored unchanged");
  chk_write_odd: assert property (wr_en |-> ^{wr_word.data[29:15], wr_word.par_hi}
    || st.perr || !st.write) else $error("written parity not odd");
  chk_perr_source: assert property (rsp_out.perr |-> $past(st.cnt == CSBS_READ_CNT && (err_hi || err_lo)))
    else $error("parity interrupt without mismatch");
endmodule

// [design/csbs_storage.sv]
`timescale 1ns/1ps
module csbs_storage
  import csbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // manual switches, asynchronous
  input wire logic straight_mode_in,
  input wire logic two_banks_in,
  // processor storage paths
  input csbs_req_t [CSBS_PORTS-1:0] req_in,
  output logic [CSBS_PORTS-1:0] grant_out,
  output logic [CSBS_PORTS-1:0] ack_out,
  output logic [CSBS_PORTS-1:0] addr_err_out,
  output logic [CSBS_PORTS-1:0][CSBS_DBL_W-1:0] rdata_out,
  // parity interrupts, one per bank
  output logic [CSBS_BANKS-1:0] par_int_out
);
  csbs_top_t st;
  csbs_top_t next_st;
  logic straight;
  logic two_banks;
  csbs_req_t cur [CSBS_PORTS];
  logic [1:0] tgt [CSBS_PORTS];
  logic [CSBS_IDX_W-1:0] widx [CSBS_PORTS];
  logic [CSBS_DATA_W-1:0] wword [CSBS_PORTS];
  logic [CSBS_DATA_W-1:0] wmask [CSBS_PORTS];
  logic ask [CSBS_PORTS];
  logic bad [CSBS_PORTS];
  logic pgnt [CSBS_PORTS];
  csbs_mreq_t mreq [CSBS_MODS];
  csbs_mrsp_t mrsp [CSBS_MODS];
  logic mgnt [CSBS_MODS];
  logic win1 [CSBS_MODS];

  // first stage feeds only the second
  assign straight = st.sw_s2[0];
  assign two_banks = st.sw_s2[1];

  function automatic logic [CSBS_DATA_W-1:0] mask_of(input csbs_req_t r);
    logic [CSBS_DATA_W-1:0] m;
    m = CSBS_FULL_MASK;
    unique case (r.kind)
      CSBS_UPPER: m = CSBS_UPPER_MASK;
      CSBS_LOWER: m = CSBS_LOWER_MASK;
      CSBS_FIELD: m = r.mask;
      default: m = CSBS_FULL_MASK;
    endcase
    return m;
  endfunction

  // address decode per processor path
  always_comb
  begin
    for (int p = 0; p < CSBS_PORTS; p++)
    begin
      cur[p] = (st.port[p].pst == CSBS_P_IDLE) ? req_in[p] : st.port[p].req;
      tgt[p][1] = cur[p].addr[CSBS_BANK_BIT];
      if (straight)
      begin
        tgt[p][0] = cur[p].addr[CSBS_STR_MOD_BIT];
        widx[p] = cur[p].addr[CSBS_IDX_W-1:0];
      end
      else
      begin
        tgt[p][0] = cur[p].addr[CSBS_ILV_MOD_BIT];
        widx[p] = cur[p].addr[CSBS_IDX_W:1];
      end
      bad[p] = !two_banks && cur[p].addr[CSBS_BANK_BIT];
      ask[p] = ((st.port[p].pst == CSBS_P_IDLE && req_in[p].valid) || st.port[p].pst == CSBS_P_ASK) && !bad[p];
      wmask[p] = mask_of(cur[p]);
      if (cur[p].kind == CSBS_DOUBLE && !st.port[p].second && st.port[p].pst == CSBS_P_IDLE)
      begin
        wword[p] = cur[p].wdata[CSBS_DBL_W-1:CSBS_DATA_W];
      end
      else
      begin
        wword[p] = cur[p].wdata[CSBS_DATA_W-1:0];
      end
    end
  end

  // path 0 wins a module both paths want; distinct modules run in parallel
  always_comb
  begin
    for (int m = 0; m < CSBS_MODS; m++)
    begin
      logic w0;
      logic w1;
      w0 = ask[0] && tgt[0] == 2'(m);
      w1 = ask[1] && tgt[1] == 2'(m);
      win1[m] = !w0 && w1;
      mreq[m].sel = w0 || w1;
      mreq[m].write = win1[m] ? cur[1].write : cur[0].write;
      mreq[m].addr = win1[m] ? widx[1] : widx[0];
      mreq[m].mask = win1[m] ? wmask[1] : wmask[0];
      mreq[m].wdata = win1[m] ? wword[1] : wword[0];
    end
    for (int p = 0; p < CSBS_PORTS; p++)
    begin
      pgnt[p] = ask[p] && mgnt[tgt[p]] && (win1[tgt[p]] == (p == 1));
    end
  end

  for (genvar g = 0; g < CSBS_MODS; g++)
  begin : g_mod
    csbs_module u_mod (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .mreq_in(mreq[g]),
      .gnt_out(mgnt[g]),
      .rsp_out(mrsp[g])
    );
  end

  always_comb
  begin
    for (int p = 0; p < CSBS_PORTS; p++)
    begin
      grant_out[p] = st.port[p].pst == CSBS_P_IDLE && req_in[p].valid && (bad[p] || pgnt[p]);
      ack_out[p] = st.port[p].ack;
      addr_err_out[p] = st.port[p].aerr;
      rdata_out[p] = st.port[p].rdata;
    end
    par_int_out = st.par_int;
  end

  always_comb
  begin
    next_st = st;
    next_st.sw_s1 = {two_banks_in, straight_mode_in};
    next_st.sw_s2 = st.sw_s1;
    for (int b = 0; b < CSBS_BANKS; b++)
    begin
      next_st.par_int[b] = mrsp[2*b].perr || mrsp[2*b+1].perr;
    end
    for (int p = 0; p < CSBS_PORTS; p++)
    begin
      next_st.port[p].ack = 1'b0;
      next_st.port[p].aerr = 1'b0;
      unique case (st.port[p].pst)
        CSBS_P_IDLE:
        begin
          if (req_in[p].valid && bad[p])
          begin
            next_st.port[p].ack = 1'b1;
            next_st.port[p].aerr = 1'b1;
            next_st.port[p].rdata = '0;
          end
          else if (pgnt[p])
          begin
            next_st.port[p].req = req_in[p];
            next_st.port[p].mod = tgt[p];
            next_st.port[p].second = 1'b0;
            next_st.port[p].pst = CSBS_P_WAIT;
          end
        end
        CSBS_P_ASK:
        begin
          // second half of a double word may cross into a missing bank
          if (bad[p])
          begin
            next_st.port[p].ack = 1'b1;
            next_st.port[p].aerr = 1'b1;
            next_st.port[p].pst = CSBS_P_IDLE;
          end
          else if (pgnt[p])
          begin
            next_st.port[p].mod = tgt[p];
            next_st.port[p].pst = CSBS_P_WAIT;
          end
        end
        CSBS_P_WAIT:
        begin
          if (mrsp[st.port[p].mod].ack)
          begin
            if (st.port[p].req.kind == CSBS_DOUBLE && !st.port[p].second)
            begin
              next_st.port[p].rdata[CSBS_DBL_W-1:CSBS_DATA_W] = mrsp[st.port[p].mod].rdata;
              next_st.port[p].req.addr = st.port[p].req.addr + 17'h00001;
              next_st.port[p].second = 1'b1;
              next_st.port[p].pst = CSBS_P_ASK;
            end
            else
            begin
              if (!st.port[p].second)
              begin
                next_st.port[p].rdata[CSBS_DBL_W-1:CSBS_DATA_W] = '0;
              end
              next_st.port[p].rdata[CSBS_DATA_W-1:0] = mrsp[st.port[p].mod].rdata;
              next_st.port[p].ack = 1'b1;
              next_st.port[p].pst = CSBS_P_IDLE;
            end
          end
        end
        default:
        begin
          next_st.port[p].pst = CSBS_P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st <= CSBS_TOP_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_interleave_sel: assert property (grant_out[0] && !addr_err_out[0] && !straight && !bad[0]
    |-> mgnt[{req_in[0].addr[16], req_in[0].addr[0]}]) else $error("interleaved decode picked wrong module");
  chk_straight_sel: assert property (grant_out[0] && straight && !bad[0]
    |-> mgnt[{req_in[0].addr[16], req_in[0].addr[15]}]) else $error("straight decode picked wrong module");
  chk_word_index: assert property (pgnt[0] && !straight && st.port[0].pst == CSBS_P_IDLE
    |-> mreq[tgt[0]].addr == req_in[0].addr[15:1]) else $error("module word index wrong");
  chk_paths_apart: assert property (pgnt[0] && pgnt[1] |-> tgt[0] != tgt[1])
    else $error("two paths granted one module");
  chk_grant_ack: assert property (grant_out[0] |-> ##[1:20] ack_out[0])
    else $error("no acknowledge after grant");
  chk_missing_bank: assert property (st.port[0].pst == CSBS_P_IDLE && req_in[0].valid && !two_banks
    && req_in[0].addr[16] |=> ack_out[0] && addr_err_out[0]) else $error("missing bank not refused");
  chk_bank_int: assert property (par_int_out[1] |-> $past(mrsp[2].perr || mrsp[3].perr))
    else $error("bank 1 parity interrupt without cause");

  cov_double_done: cover property (ack_out[0] && st.port[0].second);
  cov_parity_int: cover property (|par_int_out);
  cov_parallel: cover property (pgnt[0] && pgnt[1]);
  cov_straight: cover property (grant_out[1] && straight);
endmodule

// [dv/csbs_cpu_model.sv]
`timescale 1ns/1ps
module csbs_cpu_model
  import csbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // command from the bench
  input wire logic go_in,
  input csbs_req_t cmd_in,
  // storage path
  output csbs_req_t req_out,
  input wire logic grant_in,
  input wire logic ack_in,
  input wire logic aerr_in,
  input wire logic [CSBS_DBL_W-1:0] rdata_in,
  // outcome of the last reference
  output logic busy_out,
  output logic aerr_out,
  output logic [7:0] lat_out,
  output logic [CSBS_DBL_W-1:0] data_out
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      req_out <= '0;
      busy_out <= 1'b0;
      aerr_out <= 1'b0;
      lat_out <= 8'h00;
      data_out <= '0;
      cnt <= 8'h00;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      if (go_in)
      begin
        req_out <= cmd_in;
        busy_out <= 1'b1;
        cnt <= 8'h00;
      end
      else if (req_out.valid && grant_in)
      begin
        // released fields show the inverse so a late sample cannot match
        req_out.valid <= 1'b0;
        req_out.addr <= ~req_out.addr;
        req_out.mask <= ~req_out.mask;
        req_out.wdata <= ~req_out.wdata;
      end
      if (busy_out && ack_in)
      begin
        busy_out <= 1'b0;
        lat_out <= cnt;
        data_out <= rdata_in;
        aerr_out <= aerr_in;
      end
    end
  end
endmodule

// [dv/test_core_storage_bank_select.sv]
`timescale 1ns/1ps
module test_core_storage_bank_select;
  import csbs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic straight_mode_in = 1'b0;
  logic two_banks_in = 1'b0;
  csbs_req_t [1:0] req;
  csbs_req_t [1:0] cmd = '0;
  logic [1:0] go = 2'b00;
  logic [1:0] grant, ack, aerr, par_int, busy, m_aerr;
  logic [1:0][CSBS_DBL_W-1:0] rdata, data;
  logic [1:0][7:0] lat;
  logic [7:0] par_seen = 8'h00;
  int error_cnt = 0;
  int samples_checked = 0;
  localparam logic [29:0] D1 = 30'h12345678, D2 = 30'h2abcdef1, D3 = 30'h0f0f0f0f;

  csbs_storage dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .straight_mode_in(straight_mode_in),
    .two_banks_in(two_banks_in), .req_in(req), .grant_out(grant), .ack_out(ack), .addr_err_out(aerr),
    .rdata_out(rdata), .par_int_out(par_int));
  for (genvar p = 0; p < 2; p++)
  begin : g_cpu
    csbs_cpu_model cpu (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .go_in(go[p]), .cmd_in(cmd[p]),
      .req_out(req[p]), .grant_in(grant[p]), .ack_in(ack[p]), .aerr_in(aerr[p]), .rdata_in(rdata[p]),
      .busy_out(busy[p]), .aerr_out(m_aerr[p]), .lat_out(lat[p]), .data_out(data[p]));
  end

  initial
  begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    if (!rst_in && par_int !== 2'b00)
      par_seen <= par_seen + 8'h01;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_word(input string name, input logic [59:0] e, input logic [59:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cmp_flag(input string name, input logic e, input logic g);
    cmp_word(name, {59'h0, e}, {59'h0, g});
  endtask
  task automatic cmp_count(input string name, input logic [7:0] e, input logic [7:0] g);
    cmp_word(name, {52'h0, e}, {52'h0, g});
  endtask
  function automatic csbs_req_t mk(logic wr, csbs_kind_t k, logic [16:0] a, logic [29:0] m, logic [59:0] d);
    csbs_req_t r;
    r = '{valid: 1'b1, write: wr, kind: k, addr: a, mask: m, wdata: d};
    return r;
  endfunction
  task automatic launch(input logic [1:0] which, input csbs_req_t c0, input csbs_req_t c1);
    int i;
    @(posedge sys_clk_in);
    cmd[0] <= c0;
    cmd[1] <= c1;
    go <= which;
    @(posedge sys_clk_in);
    go <= 2'b00;
    #1;
    for (i = 0; i < 60 && busy !== 2'b00; i++)
    begin
      @(posedge sys_clk_in);
      #1;
    end
    if (i == 60)
      cmp_flag("busy", 1'b0, 1'b1);
  endtask
  task automatic one(input logic wr, input csbs_kind_t k, input logic [16:0] a, input logic [29:0] m,
    input logic [59:0] d);
    launch(2'b01, mk(wr, k, a, m, d), '0);
  endtask
  task automatic set_sw(input logic s, input logic b);
    @(posedge sys_clk_in);
    straight_mode_in <= s;
    two_banks_in <= b;
    repeat (3) @(posedge sys_clk_in);
  endtask

  task automatic t_reset();
    #1;
    cmp_flag("ack0", 1'b0, ack[0]);
    cmp_word("rdata0", '0, rdata[0]);
  endtask
  task automatic t_interleave();
    one(1'b1, CSBS_FULL, 17'h00002, '0, {30'h0, D1});
    cmp_count("lat_w", 8'h09, lat[0]);
    one(1'b1, CSBS_FULL, 17'h00003, '0, {30'h0, D2});
    launch(2'b11, mk(1'b0, CSBS_FULL, 17'h00002, '0, '0), mk(1'b0, CSBS_FULL, 17'h00003, '0, '0));
    cmp_count("lat_p0", 8'h09, lat[0]);
    cmp_count("lat_p1", 8'h09, lat[1]);
    cmp_word("even", {30'h0, D1}, data[0]);
    cmp_word("odd", {30'h0, D2}, data[1]);
    launch(2'b11, mk(1'b1, CSBS_FULL, 17'h00004, '0, {30'h0, D3}), mk(1'b1, CSBS_FULL, 17'h00006, '0, '0));
    cmp_count("same_p0", 8'h09, lat[0]);
    cmp_count("same_p1", 8'h11, lat[1]);
  endtask
  task automatic t_straight();
    set_sw(1'b1, 1'b0);
    launch(2'b11, mk(1'b0, CSBS_FULL, 17'h00001, '0, '0), mk(1'b0, CSBS_FULL, 17'h08001, '0, '0));
    cmp_word("str_m0", {30'h0, D1}, data[0]);
    cmp_word("str_m1", {30'h0, D2}, data[1]);
    cmp_count("str_lat", 8'h09, lat[1]);
    launch(2'b11, mk(1'b0, CSBS_FULL, 17'h00001, '0, '0), mk(1'b0, CSBS_FULL, 17'h00002, '0, '0));
    cmp_word("str_next", {30'h0, D3}, data[1]);
    cmp_count("str_same", 8'h11, lat[1]);
    set_sw(1'b0, 1'b0);
  endtask
  task automatic t_banks();
    one(1'b0, CSBS_FULL, 17'h10000, '0, '0);
    cmp_flag("miss_err", 1'b1, m_aerr[0]);
    cmp_count("miss_lat", 8'h01, lat[0]);
    set_sw(1'b0, 1'b1);
    one(1'b1, CSBS_FULL, 17'h10002, '0, {30'h0, D2});
    one(1'b0, CSBS_FULL, 17'h10002, '0, '0);
    cmp_word("bank1", {30'h0, D2}, data[0]);
    cmp_flag("bank1_err", 1'b0, m_aerr[0]);
    one(1'b0, CSBS_FULL, 17'h00002, '0, '0);
    cmp_word("bank0", {30'h0, D1}, data[0]);
  endtask
  task automatic wr_rd(input csbs_kind_t k, input logic [29:0] m, input logic [29:0] d, inout logic [29:0] w);
    one(1'b1, k, 17'h00008, m, {30'h0, d});
    w = (w & ~m) | (d & m);
    one(1'b0, CSBS_FULL, 17'h00008, '0, '0);
    cmp_word("partial", {30'h0, w}, data[0]);
  endtask
  task automatic t_kinds();
    logic [29:0] w;
    w = D1;
    wr_rd(CSBS_FULL, CSBS_FULL_MASK, D1, w);
    wr_rd(CSBS_UPPER, CSBS_UPPER_MASK, D2, w);
    wr_rd(CSBS_LOWER, CSBS_LOWER_MASK, D3, w);
    wr_rd(CSBS_FIELD, 30'h00ff00ff, D2, w);
    one(1'b1, CSBS_DOUBLE, 17'h0000a, '0, {D1, D2});
    one(1'b0, CSBS_FULL, 17'h0000b, '0, '0);
    cmp_word("dbl_lo", {30'h0, D2}, data[0]);
    one(1'b0, CSBS_DOUBLE, 17'h0000a, '0, '0);
    cmp_word("dbl_rd", {D1, D2}, data[0]);
    cmp_count("par_int", 8'h00, par_seen);
  endtask

  initial
  begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    t_reset();
    t_interleave();
    t_straight();
    t_banks();
    t_kinds();
    tally_and_finish();
  end
endmodule
